// [hw/mpio_top.sv]
//
// Summary of operation
// - sixty-five bidirectional pins under software control
// - ports accept bit and byte manipulation
// - pins carry peripheral alternate signals
// - direction selectable per bit
// - pull-up enabled per bit by software
// - led and two-wire pins are open-drain, no pull-up
// - key port raises key-return interrupt flag
// - falling edge sets flag, gated by mode bit
// - reset puts every pin in input mode
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "mpio_regs.svh"
module mpio_top import mpio_pkg::*; (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [`MPIO_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // port pins
   input  wire mpio_pins_t        pin_in,
   output mpio_pins_t             pin_out,
   output mpio_pins_t             pin_oe,
   output mpio_pins_t             pullup_en,
   // peripheral alternate functions
   input  wire mpio_pins_t        alt_out_en,
   input  wire mpio_pins_t        alt_out,
   output mpio_pins_t             alt_in,
   // interrupt
   output logic                   irq
);

   localparam mpio_pins_t PIN_MASK  = `MPIO_PIN_MASK;
   localparam mpio_pins_t PULL_MASK = `MPIO_PULL_MASK;
   localparam mpio_pins_t OD_MASK   = `MPIO_OD_MASK;

   logic [1:0]    rst_sync_r;
   logic          rst_sync_n;
   mpio_top_st_t  st_r;
   mpio_top_st_t  st_nxt;
   mpio_apb_req_t apb_req;
   mpio_apb_rsp_t apb_rsp;
   logic          wr_en;
   logic [31:0]   rd_data;
   logic          addr_hit;
   logic          key_fall;

   // reset release through two flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_sync_n = rst_sync_r[1];

   // true when the address falls in a port block
   function automatic logic port_hit(input logic [`MPIO_AW-1:0] a);
      logic [3:0] idx;
      idx = a[7:4];
      port_hit = (a[11:8] == 4'h0) && (idx < 4'(`MPIO_NPORT)) && (a[1:0] == 2'h0);
   endfunction

   // port index of a port block address
   function automatic logic [3:0] port_idx(input logic [`MPIO_AW-1:0] a);
      port_idx = a[7:4];
   endfunction

   // register within a port block
   function automatic logic [1:0] port_reg(input logic [`MPIO_AW-1:0] a);
      port_reg = a[3:2];
   endfunction

   // read value of a port: latch for outputs, pin level for inputs
   function automatic mpio_byte_t port_read(
      input mpio_byte_t latch,
      input mpio_byte_t dir,
      input mpio_byte_t pin,
      input mpio_byte_t mask
   );
      port_read = ((dir & pin) | (~dir & latch)) & mask;
   endfunction

   assign apb_req.psel    = psel;
   assign apb_req.penable = penable;
   assign apb_req.pwrite  = pwrite;
   assign apb_req.paddr   = paddr;
   assign apb_req.pwdata  = pwdata;

   mpio_apb_slave u_apb (
      .clk        (clk),
      .rst_sync_n (rst_sync_n),
      .req        (apb_req),
      .rsp        (apb_rsp),
      .rd_data    (rd_data),
      .addr_hit   (addr_hit),
      .wr_en      (wr_en)
   );

   mpio_fall_det u_key_det (
      .clk        (clk),
      .rst_sync_n (rst_sync_n),
      .pins       (st_r.pin_q[`MPIO_KEY_PORT]),
      .det_en     (st_r.key_det_en),
      .fall       (key_fall)
   );

   // address decode and read data
   always_comb begin
      logic [3:0] idx;
      idx      = port_idx(paddr);
      rd_data  = 32'h0000_0000;
      addr_hit = 1'b0;
      if (port_hit(paddr)) begin
         addr_hit = 1'b1;
         if (port_reg(paddr) == `MPIO_OFS_DATA) begin
            rd_data[7:0] = port_read(st_r.latch[idx], st_r.dir[idx],
                                     st_r.pin_q[idx], PIN_MASK[idx]);
         end else if (port_reg(paddr) == `MPIO_OFS_DIR) begin
            rd_data[7:0] = st_r.dir[idx];
         end else if (port_reg(paddr) == `MPIO_OFS_PULL) begin
            rd_data[7:0] = st_r.pull[idx];
         end else begin
            rd_data[7:0] = port_read(st_r.latch[idx], st_r.dir[idx],
                                     st_r.pin_q[idx], PIN_MASK[idx]);
         end
      end else if (paddr == `MPIO_OFS_IRQ_STAT) begin
         addr_hit                 = 1'b1;
         rd_data[`MPIO_KEY_BIT]   = st_r.key_flag;
      end else if (paddr == `MPIO_OFS_IRQ_MASK) begin
         addr_hit                 = 1'b1;
         rd_data[`MPIO_KEY_BIT]   = st_r.key_mask;
      end else if (paddr == `MPIO_OFS_EDGE_CTL) begin
         addr_hit                 = 1'b1;
         rd_data[0]               = st_r.key_det_en;
      end
   end

   // next state
   always_comb begin
      logic [3:0] idx;
      logic       key_clr;
      mpio_byte_t set_m;
      mpio_byte_t clr_m;
      mpio_byte_t val;
      logic       drive;
      st_nxt  = st_r;
      idx     = port_idx(paddr);
      key_clr = 1'b0;
      set_m   = pwdata[`MPIO_BITOP_SET_LSB +: 8];
      clr_m   = pwdata[`MPIO_BITOP_CLR_LSB +: 8];
      val     = 8'h00;
      drive   = 1'b0;

      // pins are synchronous, one sample register
      st_nxt.pin_q = pin_in & PIN_MASK;

      // register writes
      if (wr_en) begin
         if (port_hit(paddr)) begin
            if (port_reg(paddr) == `MPIO_OFS_DATA) begin
               st_nxt.latch[idx] = pwdata[7:0] & PIN_MASK[idx];
            end else if (port_reg(paddr) == `MPIO_OFS_DIR) begin
               st_nxt.dir[idx] = pwdata[7:0] | ~PIN_MASK[idx];
            end else if (port_reg(paddr) == `MPIO_OFS_PULL) begin
               st_nxt.pull[idx] = pwdata[7:0] & PULL_MASK[idx];
            end else begin
               // single-bit manipulation, clear applied after set
               st_nxt.latch[idx] = ((st_r.latch[idx] | set_m) & ~clr_m)
                                   & PIN_MASK[idx];
            end
         end else if (paddr == `MPIO_OFS_IRQ_STAT) begin
            key_clr = pwdata[`MPIO_KEY_BIT];
         end else if (paddr == `MPIO_OFS_IRQ_MASK) begin
            st_nxt.key_mask = pwdata[`MPIO_KEY_BIT];
         end else if (paddr == `MPIO_OFS_EDGE_CTL) begin
            st_nxt.key_det_en = pwdata[0];
         end
      end

      // sticky key flag, a new edge wins over a clear
      st_nxt.key_flag = (st_r.key_flag & ~key_clr) | key_fall;
      st_nxt.irq      = st_nxt.key_flag & st_nxt.key_mask;

      // pin drivers
      for (int p = 0; p < `MPIO_NPORT; p++) begin
         for (int b = 0; b < 8; b++) begin
            // alternate output is or-ed onto a cleared latch
            val[b] = st_nxt.latch[p][b] | (alt_out_en[p][b] & alt_out[p][b]);
            drive  = ~st_nxt.dir[p][b] & PIN_MASK[p][b];
            if (OD_MASK[p][b]) begin
               st_nxt.pin_o[p][b]  = 1'b0;
               st_nxt.pin_oe[p][b] = drive & ~val[b];
            end else begin
               st_nxt.pin_o[p][b]  = val[b] & drive;
               st_nxt.pin_oe[p][b] = drive;
            end
            st_nxt.pull_en[p][b] = st_nxt.pull[p][b] & st_nxt.dir[p][b]
                                   & PULL_MASK[p][b];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_r            <= '0;
         st_r.dir        <= {`MPIO_NPORT{`MPIO_DIR_RST}};
         st_r.latch      <= {`MPIO_NPORT{`MPIO_LATCH_RST}};
         st_r.pull       <= {`MPIO_NPORT{`MPIO_PULL_RST}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata    = apb_rsp.prdata;
   assign pready    = apb_rsp.pready;
   assign pslverr   = apb_rsp.pslverr;
   assign pin_out   = st_r.pin_o;
   assign pin_oe    = st_r.pin_oe;
   assign pullup_en = st_r.pull_en;
   assign alt_in    = st_r.pin_q;
   assign irq       = st_r.irq;

endmodule

// [hw/mpio_regs.svh]
`ifndef MPIO_REGS_SVH
`define MPIO_REGS_SVH

// port count and apb address width
`define MPIO_NPORT        9
`define MPIO_AW           12

// per-port register block
`define MPIO_PORT_STRIDE  12'h010
`define MPIO_OFS_DATA     2'h0
`define MPIO_OFS_DIR      2'h1
`define MPIO_OFS_PULL     2'h2
`define MPIO_OFS_BITOP    2'h3

// bit set / clear fields of the bit operation register
`define MPIO_BITOP_SET_LSB 0
`define MPIO_BITOP_CLR_LSB 8

// interrupt and edge control registers
`define MPIO_OFS_IRQ_STAT 12'h100
`define MPIO_OFS_IRQ_MASK 12'h104
`define MPIO_OFS_EDGE_CTL 12'h108
`define MPIO_KEY_BIT      0
`define MPIO_KEY_PORT     3

// reset values
`define MPIO_DIR_RST      8'hFF
`define MPIO_LATCH_RST    8'h00
`define MPIO_PULL_RST     8'h00

// bit maps, port index 8 down to 0 = ports 9,8,7,6,5,4,3,2,0
`define MPIO_PIN_MASK     72'hFF_FF_3F_F0_FF_FF_7F_FF_FF
`define MPIO_PULL_MASK    72'h00_00_33_F0_FF_FF_77_FF_FF
`define MPIO_OD_MASK      72'h00_00_0C_00_00_00_08_00_00

`endif

// [hw/mpio_pkg.sv]
package mpio_pkg;
`include "mpio_regs.svh"

   typedef logic [7:0]                     mpio_byte_t;
   typedef logic [`MPIO_NPORT-1:0][7:0]    mpio_pins_t;

   typedef struct packed {
      logic                psel;
      logic                penable;
      logic                pwrite;
      logic [`MPIO_AW-1:0] paddr;
      logic [31:0]         pwdata;
   } mpio_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } mpio_apb_rsp_t;

   typedef struct packed {
      mpio_byte_t prev;
      logic       fall;
   } mpio_edge_st_t;

   typedef struct packed {
      mpio_pins_t latch;
      mpio_pins_t dir;
      mpio_pins_t pull;
      mpio_pins_t pin_q;
      mpio_pins_t pin_o;
      mpio_pins_t pin_oe;
      mpio_pins_t pull_en;
      logic       key_flag;
      logic       key_mask;
      logic       key_det_en;
      logic       irq;
   } mpio_top_st_t;

endpackage

// [hw/mpio_apb_slave.sv]
`timescale 1ns/10ps
module mpio_apb_slave import mpio_pkg::*; (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_sync_n,
   // bus side
   input  wire mpio_apb_req_t req,
   output mpio_apb_rsp_t      rsp,
   // register file side
   input  wire logic [31:0]   rd_data,
   input  wire logic          addr_hit,
   output logic               wr_en
);

   mpio_apb_rsp_t st_r;
   mpio_apb_rsp_t st_nxt;

   // answer is prepared in the setup cycle, shown in the access cycle
   always_comb begin
      st_nxt         = st_r;
      st_nxt.pready  = req.psel & ~req.penable;
      st_nxt.pslverr = req.psel & ~req.penable & ~addr_hit;
      if (req.psel && !req.penable && !req.pwrite && addr_hit) begin
         st_nxt.prdata = rd_data;
      end else begin
         st_nxt.prdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rsp   = st_r;
   assign wr_en = req.psel & req.penable & req.pwrite & st_r.pready & ~st_r.pslverr;

endmodule

// [hw/mpio_fall_det.sv]
`timescale 1ns/10ps
module mpio_fall_det import mpio_pkg::*; (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_sync_n,
   // sampled pins and enable
   input  wire mpio_byte_t pins,
   input  wire logic       det_en,
   // one-cycle falling edge pulse
   output logic            fall
);

   mpio_edge_st_t st_r;
   mpio_edge_st_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.prev = pins;
      st_nxt.fall = det_en & (|(st_r.prev & ~pins));
   end

   // prev resets high so a low pin at release reads as an edge
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_r <= '{prev: 8'hFF, fall: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fall = st_r.fall;

endmodule

// [tb/mpio_top_assertions.sv]
`timescale 1ns/10ps
`include "mpio_regs.svh"
module mpio_top_assertions import mpio_pkg::*; (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // pins
   input wire mpio_pins_t  pin_in,
   input wire mpio_pins_t  pin_out,
   input wire mpio_pins_t  pin_oe,
   input wire mpio_pins_t  pullup_en,
   input wire mpio_pins_t  alt_in
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_setup; psel && !penable |=> pready; endproperty
   a_setup: assert property (p_setup) else $error("no ready");
   property p_acc; pready |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("stray ready");
   property p_rd0; !pready |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("prdata idle");
   property p_oe; (pin_oe & ~`MPIO_PIN_MASK) == '0; endproperty
   a_oe: assert property (p_oe) else $error("oe on absent pin");
   property p_od; (pin_out & `MPIO_OD_MASK) == '0; endproperty
   a_od: assert property (p_od) else $error("od pin driven high");
   property p_pum; (pullup_en & ~`MPIO_PULL_MASK) == '0; endproperty
   a_pum: assert property (p_pum) else $error("bad pull-up");
   property p_pui; (pullup_en & pin_oe) == '0; endproperty
   a_pui: assert property (p_pui) else $error("pull-up on output");
   property p_alt;
      $past(rst_n, 4) |-> ((alt_in ^ $past(pin_in)) & `MPIO_PIN_MASK) == '0;
   endproperty
   a_alt: assert property (p_alt) else $error("alt_in lag");
endmodule
bind mpio_top mpio_top_assertions u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .alt_in(alt_in));

// [tb/mpio_pin_world.sv]
`timescale 1ns/10ps
module mpio_pin_world import mpio_pkg::*; (
   // clock
   input wire logic       clk,
   // block side
   input wire mpio_pins_t pin_out,
   input wire mpio_pins_t pin_oe,
   input wire mpio_pins_t pullup_en,
   // board drive
   input wire mpio_pins_t ext_en,
   input wire mpio_pins_t ext_val,
   output mpio_pins_t     pin_in
);
   mpio_pins_t last = '0;
   mpio_pins_t held;
   assign held = pin_oe | ext_en | pullup_en;
   // floating pins show the inverse of their last driven level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pullup_en | ~last));
   always_ff @(posedge clk) last <= (held & pin_in) | (~held & last);
endmodule

// [tb/multi_port_io_block_bench.sv]
`timescale 1ns/10ps
`include "mpio_regs.svh"
module multi_port_io_block_bench import mpio_pkg::*; ;
   logic                clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [`MPIO_AW-1:0] paddr = '0;
   logic [31:0]         pwdata = '0, prdata, q;
   logic                pready, pslverr, irq, e;
   mpio_pins_t          pin_in, pin_out, pin_oe, pullup_en, alt_in;
   mpio_pins_t          alt_out_en = '0, alt_out = '0, ext_en = '0, ext_val = '0;
   int                  num_errors = 0, checks = 0;
   initial forever #5 clk = ~clk;
   mpio_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_en(pullup_en), .alt_out_en(alt_out_en),
      .alt_out(alt_out), .alt_in(alt_in), .irq(irq));
   mpio_pin_world pw (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   task automatic summarize;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   initial begin
      #200us;
      num_errors++;
      summarize;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk(pin_oe | pullup_en, '0);
      for (int i = 0; i < 9; i++) rd(12'(i * 16 + 4), 32'hFF);
      apb(1'b1, 12'h004, 32'hF0);
      apb(1'b1, 12'h000, 32'hA5);
      apb(1'b1, 12'h00C, 32'h0102);
      ext_en[0] <= 8'hF0;
      ext_val[0] <= 8'h90;
      apb(1'b1, 12'h008, 32'hFF);
      chk(pin_oe[0], 8'h0F);
      chk(pin_out[0] & pin_oe[0], 8'h06);
      chk(pullup_en[0], 8'hF0);
      rd(12'h000, 32'h96);
      rd(12'h00C, 32'h96);
      apb(1'b1, 12'h028, 32'hFF);
      rd(12'h028, 32'h77);
      apb(1'b1, 12'h024, 32'h77);
      rd(12'h024, 32'hF7);
      apb(1'b1, 12'h020, 32'h00);
      chk({pin_oe[2], pin_out[2], pullup_en[2]}, 24'h080077);
      apb(1'b1, 12'h020, 32'h08);
      chk(pin_oe[2], 8'h00);
      apb(1'b1, 12'h014, 32'hFE);
      apb(1'b1, 12'h010, 32'h00);
      alt_out_en[1] <= 8'h01;
      alt_out[1] <= 8'h01;
      repeat (2) @(posedge clk);
      chk(pin_out[1], 8'h01);
      ext_en[3] <= 8'hFF;
      ext_val[3] <= 8'hFF;
      repeat (3) @(posedge clk);
      ext_val[3] <= 8'hFE;
      repeat (5) @(posedge clk);
      rd(12'h100, 32'h0);
      apb(1'b1, 12'h108, 32'h1);
      rd(12'h108, 32'h1);
      ext_val[3] <= 8'hFF;
      repeat (3) @(posedge clk);
      ext_val[3] <= 8'h7E;
      repeat (5) @(posedge clk);
      chk(irq, 1'b0);
      rd(12'h100, 32'h1);
      apb(1'b1, 12'h104, 32'h1);
      chk(irq, 1'b1);
      rd(12'h104, 32'h1);
      apb(1'b1, 12'h100, 32'h1);
      chk(irq, 1'b0);
      rd(12'h100, 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      chk({e, q}, {1'b1, 32'h0});
      summarize;
   end
endmodule
